// [inc/apdm_pkg.sv]
// Purpose: constants for the automatic power-down manager
// Assumes: 8-bit register port, one clock at 20 MHz
// Notes: offsets index an 8-bit register space
// Notes on behaviour
// - with auto power-down on and strobe static, a four-bit idle counter runs
// - fifteen idle logic-clock periods raise the power-down flag, enter power-down
// - enabling auto power-down alone enables power-down entry
// - strobe pulsing again returns the device to normal operation
// - module select low or warm reset high also ends power-down; the code wakes only on a falling edge of module select
// - power-down blocks the microcontroller bus from memories and logic arrays; the code raises busBlock but still passes pldWrite and pldRead
// - power-down deselects flash and SRAM regardless of bus activity; I/O follows module select
// - gating the logic clock from the arrays never stops the idle counter
// - in power-down ports hold, address-out undefined, peripheral pins float
// - module select low enables flash, SRAM and I/O for accesses
// - module select high disables flash, SRAM and I/O
// - control bit 1 turns auto power-down on or off
// - control bit 3 set turns fast logic mode off; fast is default
// - control bit 4 set cuts the logic clock from the AND array
// - control bit 5 set cuts the logic clock from macrocell flops
// - gate register bits cut write, read, store-enable and strobe from the array
// - counter idle when disabled or strobe pulsing; flag after 15 clocks
// - both registers clear at power-up and survive warm resets
package apdm_pkg;
	localparam logic [7:0] OFS_POWER_MODE = 8'h00;
	localparam logic [7:0] OFS_SIGNAL_GATE = 8'h01;
	localparam logic [7:0] OFS_STATUS = 8'h02;
	localparam logic [7:0] POWER_MODE_RESET = 8'h00;
	localparam logic [7:0] SIGNAL_GATE_RESET = 8'h00;
	localparam logic [7:0] POWER_MODE_MASK = 8'h3a;
	localparam logic [7:0] SIGNAL_GATE_MASK = 8'h3c;
	localparam int BIT_APD_ENABLE = 1;
	localparam int BIT_TURBO_OFF = 3;
	localparam int BIT_ARRAY_CLK_OFF = 4;
	localparam int BIT_MCELL_CLK_OFF = 5;
	localparam int BIT_GATE_WRITE = 2;
	localparam int BIT_GATE_READ = 3;
	localparam int BIT_GATE_STORE = 4;
	localparam int BIT_GATE_STROBE = 5;
	localparam logic [3:0] IDLE_LIMIT = 4'hf;
	localparam logic [3:0] IDLE_LAST_STEP = 4'he;
	typedef enum logic [1:0] {
		APDM_ACTIVE = 2'b01,
		APDM_POWERDOWN = 2'b10
	} apdm_state_type;
endpackage : apdm_pkg

// [verilog/apdm_manager.sv]
// Purpose: automatic power-down unit with power mode and signal gate registers
// Assumes: all inputs synchronous to clock; logic clock sampled as a level
// Notes: outputs are registered, so they trail their causes by one cycle
`timescale 1ns/1ps
module apdm_manager
	import apdm_pkg::*;
(
	// clock and power-up reset
	input wire logic clock,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	// microcontroller and pin inputs
	input wire logic addressStrobe,
	input wire logic logicInputClock,
	input wire logic moduleSelectN,
	input wire logic warmReset,
	input wire logic mcuWrite,
	input wire logic mcuRead,
	input wire logic programStoreEnable,
	// power-down status and memory selects
	output logic powerDownFlag,
	output logic busBlock,
	output logic flashEnable,
	output logic sramEnable,
	output logic ioEnable,
	// logic array controls
	output logic pldTurboOn,
	output logic pldArrayClkEnable,
	output logic macrocellClkEnable,
	output logic pldWrite,
	output logic pldRead,
	output logic pldProgramStore,
	output logic pldAddressStrobe,
	// port behaviour
	output logic portHold,
	output logic peripheralOe
);

	logic [7:0] powerModeReg;
	logic [7:0] signalGateReg;
	logic [3:0] idleCountReg;
	logic [3:0] idleCountNext;
	apdm_state_type stateReg;
	apdm_state_type stateNext;
	logic strobePrevReg;
	logic clkPrevReg;
	logic selPrevReg;

	// register decode
	wire hitPowerMode = (regAddr == OFS_POWER_MODE);
	wire hitSignalGate = (regAddr == OFS_SIGNAL_GATE);
	wire hitStatus = (regAddr == OFS_STATUS);
	wire writePowerMode = regWrite && hitPowerMode;
	wire writeSignalGate = regWrite && hitSignalGate;
	// reserved bits are not stored, so they read as zero
	wire [7:0] powerModeNext = regWdata & POWER_MODE_MASK;
	wire [7:0] signalGateNext = regWdata & SIGNAL_GATE_MASK;

	// control bits
	wire apdEnabled = powerModeReg[BIT_APD_ENABLE];
	wire turboOff = powerModeReg[BIT_TURBO_OFF];
	wire arrayClkOff = powerModeReg[BIT_ARRAY_CLK_OFF];
	wire mcellClkOff = powerModeReg[BIT_MCELL_CLK_OFF];

	// activity detection on the raw pins
	wire strobeToggle = (addressStrobe != strobePrevReg);
	// ungated logic clock: array gating bits never touch this edge
	wire clkRise = logicInputClock && !clkPrevReg;
	wire selectFall = !moduleSelectN && selPrevReg;
	wire inPowerDown = (stateReg == APDM_POWERDOWN);
	// wake sources; select low taken as its falling edge
	wire wakeUp = strobeToggle || warmReset || selectFall;
	wire lastIdleStep = (idleCountReg == IDLE_LAST_STEP) && clkRise;

	// read mux; unmapped offsets answer zero
	wire [7:0] statusWord = {idleCountReg, 3'h0, inPowerDown};
	wire [7:0] readMux = hitPowerMode ? powerModeReg :
		hitSignalGate ? signalGateReg :
		hitStatus ? statusWord : 8'h00;

	// next-state and idle counter
	always_comb begin
		stateNext = stateReg;
		idleCountNext = idleCountReg;
		case (stateReg)
			APDM_ACTIVE: begin
				if (!apdEnabled || strobeToggle) begin
					idleCountNext = 4'h0;
				end else if (clkRise && idleCountReg != IDLE_LIMIT) begin
					idleCountNext = idleCountReg + 4'h1;
				end
				// entry needs only the enable bit, no second switch
				if (apdEnabled && !strobeToggle && lastIdleStep) begin
					stateNext = APDM_POWERDOWN;
				end
			end
			APDM_POWERDOWN: begin
				if (wakeUp || !apdEnabled) begin
					stateNext = APDM_ACTIVE;
					idleCountNext = 4'h0;
				end
			end
			default: begin
				stateNext = APDM_ACTIVE;
				idleCountNext = 4'h0;
			end
		endcase
	end

	wire pdNext = (stateNext == APDM_POWERDOWN);

	// power-up reset only; warm reset leaves these alone
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			powerModeReg <= POWER_MODE_RESET;
			signalGateReg <= SIGNAL_GATE_RESET;
		end else begin
			if (writePowerMode) powerModeReg <= powerModeNext;
			if (writeSignalGate) signalGateReg <= signalGateNext;
		end
	end

	// read data stands one cycle after the read strobe only
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= regRead ? readMux : 8'h00;
		end
	end

	// state, counter and pin history
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			stateReg <= APDM_ACTIVE;
			idleCountReg <= 4'h0;
			strobePrevReg <= 1'b0;
			clkPrevReg <= 1'b0;
			selPrevReg <= 1'b1;
		end else begin
			stateReg <= stateNext;
			idleCountReg <= idleCountNext;
			strobePrevReg <= addressStrobe;
			clkPrevReg <= logicInputClock;
			selPrevReg <= moduleSelectN;
		end
	end

	// power-down outputs follow the next state to save a cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			powerDownFlag <= 1'b0;
			busBlock <= 1'b0;
			flashEnable <= 1'b0;
			sramEnable <= 1'b0;
			ioEnable <= 1'b0;
			portHold <= 1'b0;
			peripheralOe <= 1'b0;
		end else begin
			powerDownFlag <= pdNext;
			busBlock <= pdNext;
			flashEnable <= !moduleSelectN && !pdNext;
			sramEnable <= !moduleSelectN && !pdNext;
			ioEnable <= !moduleSelectN;
			portHold <= pdNext;
			peripheralOe <= !pdNext;
		end
	end

	// array controls; a blocked input is held low, which keeps it quiet
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pldTurboOn <= 1'b1;
			pldArrayClkEnable <= 1'b1;
			macrocellClkEnable <= 1'b1;
			pldWrite <= 1'b0;
			pldRead <= 1'b0;
			pldProgramStore <= 1'b0;
			pldAddressStrobe <= 1'b0;
		end else begin
			pldTurboOn <= !turboOff;
			pldArrayClkEnable <= !arrayClkOff;
			macrocellClkEnable <= !mcellClkOff;
			pldWrite <= mcuWrite && !signalGateReg[BIT_GATE_WRITE];
			pldRead <= mcuRead && !signalGateReg[BIT_GATE_READ];
			pldProgramStore <= programStoreEnable &&
				!signalGateReg[BIT_GATE_STORE];
			pldAddressStrobe <= addressStrobe &&
				!signalGateReg[BIT_GATE_STROBE];
		end
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_enterAfterFifteen;
		(stateReg == APDM_ACTIVE) && apdEnabled && !strobeToggle &&
			lastIdleStep |=> powerDownFlag && idleCountReg == IDLE_LIMIT;
	endproperty
	a_enterAfterFifteen: assert property (p_enterAfterFifteen)
		else $error("power-down not entered at count fifteen");

	property p_idleWhenDisabled;
		!apdEnabled |=> idleCountReg == 4'h0 && !powerDownFlag;
	endproperty
	a_idleWhenDisabled: assert property (p_idleWhenDisabled)
		else $error("idle counter ran while disabled");

	property p_toggleClears;
		(stateReg == APDM_ACTIVE) && strobeToggle |=> idleCountReg == 4'h0;
	endproperty
	a_toggleClears: assert property (p_toggleClears)
		else $error("strobe edge did not clear idle counter");

	property p_countAdvances;
		(stateReg == APDM_ACTIVE) && apdEnabled && !strobeToggle &&
			clkRise && idleCountReg < IDLE_LAST_STEP
			|=> idleCountReg == $past(idleCountReg) + 4'h1;
	endproperty
	a_countAdvances: assert property (p_countAdvances)
		else $error("idle counter missed a logic clock edge");

	property p_wakeOnStrobe;
		inPowerDown && strobeToggle |=> !powerDownFlag ##1 !busBlock;
	endproperty
	a_wakeOnStrobe: assert property (p_wakeOnStrobe)
		else $error("strobe activity did not end power-down");

	property p_wakeOnReset;
		inPowerDown && (warmReset || selectFall) |=> !powerDownFlag;
	endproperty
	a_wakeOnReset: assert property (p_wakeOnReset)
		else $error("reset or select did not end power-down");

	property p_busBlocked;
		powerDownFlag |-> busBlock && !peripheralOe && portHold;
	endproperty
	a_busBlocked: assert property (p_busBlocked)
		else $error("bus not blocked in power-down");

	property p_memDeselect;
		powerDownFlag |-> !flashEnable && !sramEnable;
	endproperty
	a_memDeselect: assert property (p_memDeselect)
		else $error("memory selected in power-down");

	property p_selectHigh;
		moduleSelectN |=> !flashEnable && !sramEnable && !ioEnable;
	endproperty
	a_selectHigh: assert property (p_selectHigh)
		else $error("select high left a memory enabled");

	property p_readBack;
		writePowerMode ##1 (regRead && hitPowerMode)
			|=> regRdata == ($past(regWdata, 2) & POWER_MODE_MASK);
	endproperty
	a_readBack: assert property (p_readBack)
		else $error("power mode register read-back wrong");

	property p_warmKeeps;
		warmReset && !regWrite |=> powerModeReg == $past(powerModeReg);
	endproperty
	a_warmKeeps: assert property (p_warmKeeps)
		else $error("warm reset altered power mode register");

	property p_gateWrite;
		signalGateReg[BIT_GATE_WRITE] && !regWrite |=> !pldWrite;
	endproperty
	a_gateWrite: assert property (p_gateWrite)
		else $error("gated write strobe reached the array");

endmodule : apdm_manager

// [dv/apdm_mcu_model.sv]
// Purpose: microcontroller side model: address strobe and logic clock
// Assumes: changes only right after rising edges of the bench clock
// Notes: logic clock parks low outside runs, so no stray edges count
`timescale 1ns/1ps
module apdm_mcu_model (
	// clock
	input wire logic clock,
	// bench controls
	input wire logic strobeRun,
	input wire logic licRun,
	// pins toward the block
	output logic addressStrobe,
	output logic logicInputClock,
	output logic [7:0] riseCount
);
	// start idle so the first strobe change is the bench's own
	initial begin
		addressStrobe = 1'b0;
		logicInputClock = 1'b0;
		riseCount = 8'h00;
	end
	// strobe toggles on request; rises counted as driven
	always @(posedge clock) begin
		if (strobeRun) addressStrobe <= !addressStrobe;
		logicInputClock <= licRun ? !logicInputClock : 1'b0;
		if (!licRun) riseCount <= 8'h00;
		else if (!logicInputClock) riseCount <= riseCount + 8'h01;
	end
endmodule : apdm_mcu_model

// [dv/auto_power_down_manager_test.sv]
// Purpose: register, power-down entry and wake checks
// Assumes: register port answers one cycle after a read strobe
// Notes: flag may trail the fifteenth rise by one cycle
`timescale 1ns/1ps
module auto_power_down_manager_test
	import apdm_pkg::*;
;
	logic clock = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, riseCount;
	logic moduleSelectN = 1'b0, warmReset = 1'b0, mcuWrite = 1'b1;
	logic mcuRead = 1'b1, programStoreEnable = 1'b1;
	logic strobeRun = 1'b0, licRun = 1'b0, addressStrobe, logicInputClock;
	logic powerDownFlag, busBlock, flashEnable, sramEnable, ioEnable;
	logic pldTurboOn, pldArrayClkEnable, macrocellClkEnable, pldWrite;
	logic pldRead, pldProgramStore, pldAddressStrobe, portHold, peripheralOe;
	int n_fail = 0, n_compared = 0;
	// 20 MHz clock
	always #25 clock = !clock;
	apdm_mcu_model i_apdm_mcu_model (.clock(clock), .strobeRun(strobeRun),
		.licRun(licRun), .addressStrobe(addressStrobe),
		.logicInputClock(logicInputClock), .riseCount(riseCount));
	apdm_manager i_apdm_manager (
		.clock(clock),
		.sys_rst(sys_rst),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWrite(regWrite),
		.regRead(regRead),
		.regRdata(regRdata),
		.addressStrobe(addressStrobe),
		.logicInputClock(logicInputClock),
		.moduleSelectN(moduleSelectN),
		.warmReset(warmReset),
		.mcuWrite(mcuWrite),
		.mcuRead(mcuRead),
		.programStoreEnable(programStoreEnable),
		.powerDownFlag(powerDownFlag),
		.busBlock(busBlock),
		.flashEnable(flashEnable),
		.sramEnable(sramEnable),
		.ioEnable(ioEnable),
		.pldTurboOn(pldTurboOn),
		.pldArrayClkEnable(pldArrayClkEnable),
		.macrocellClkEnable(macrocellClkEnable),
		.pldWrite(pldWrite),
		.pldRead(pldRead),
		.pldProgramStore(pldProgramStore),
		.pldAddressStrobe(pldAddressStrobe),
		.portHold(portHold),
		.peripheralOe(peripheralOe)
	);
	task give_verdict;
		if (n_fail == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict
	task check(input string what, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task wr(input logic [7:0] a, d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr
	// called just after an edge; may follow a write with no gap
	task rd(input logic [7:0] a, exp, input string what);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		check(what, regRdata, exp);
	endtask : rd
	// bounded wait for the flag level
	task wait_pd(input logic lvl, input int bound);
		for (int i = 0; i < bound && powerDownFlag !== lvl; i++) begin
			@(posedge clock);
			#1;
		end
		check("flag", powerDownFlag, lvl);
		if (powerDownFlag !== lvl) give_verdict();
	endtask : wait_pd
	// one strobe change clears the count, then the logic clock runs
	task enter_pd;
		@(posedge clock);
		strobeRun <= 1'b1;
		@(posedge clock);
		strobeRun <= 1'b0;
		licRun <= 1'b1;
		wait_pd(1'b1, 60);
		check("rises", riseCount == 8'h0f || riseCount == 8'h10, 8'h01);
		licRun <= 1'b0;
	endtask : enter_pd
	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		rd(OFS_POWER_MODE, 8'h00, "mode");
		rd(OFS_SIGNAL_GATE, 8'h00, "gate");
		check("ctl", {pldTurboOn, pldArrayClkEnable, macrocellClkEnable}, 8'h07);
		licRun <= 1'b1;
		repeat (40) @(posedge clock);
		#1 check("off", powerDownFlag, 1'b0);
		licRun <= 1'b0;
		wr(OFS_POWER_MODE, 8'h3a);
		rd(OFS_POWER_MODE, 8'h3a, "mode");
		check("ctl", {pldTurboOn, pldArrayClkEnable, macrocellClkEnable}, 8'h00);
		wr(OFS_SIGNAL_GATE, 8'h3c);
		rd(OFS_SIGNAL_GATE, 8'h3c, "gate");
		check("gated", {pldWrite, pldRead, pldProgramStore, pldAddressStrobe}, 8'h00);
		wr(OFS_SIGNAL_GATE, 8'h00);
		@(posedge clock);
		#1 check("open", {pldWrite, pldRead, pldProgramStore}, 8'h07);
		// enable with the array clocks cut, counter must still run
		wr(OFS_POWER_MODE, 8'h32);
		for (int k = 0; k < 3; k++) begin
			if (k == 2) moduleSelectN <= 1'b1;
			enter_pd();
			check("pd", {busBlock, flashEnable, sramEnable, portHold, peripheralOe,
				ioEnable}, {5'b10010, !moduleSelectN});
			if (k == 2) check("sel", pldWrite, 1'b1);
			@(posedge clock);
			if (k == 0) strobeRun <= 1'b1;
			if (k == 1) warmReset <= 1'b1;
			if (k == 2) moduleSelectN <= 1'b0;
			@(posedge clock);
			strobeRun <= 1'b0;
			warmReset <= 1'b0;
			wait_pd(1'b0, 3);
		end
		@(posedge clock);
		#1 check("mem", {flashEnable, sramEnable, ioEnable}, 8'h07);
		rd(OFS_POWER_MODE, 8'h32, "kept");
		rd(8'h07, 8'h00, "unmapped");
		give_verdict();
	end
endmodule : auto_power_down_manager_test
